// [design/slpc_cfg.svh]
// register map constants and behaviour summary of the serial link parameter block
//
// Behaviour
// - Bit 7 of the scrambling and lane register disables the link scrambler at 0, enables it at 1, and resets to 1.
// - The five-bit lane field gives one lane for 0x0, two for 0x1, four for 0x3, eight for 0x7, and resets to 0x7.
// - The eight-bit octets-per-frame field holds F minus one and resets to zero, meaning one octet.
// - The five-bit frames-per-multiframe field holds K minus one and resets to 0x1F, meaning 32 frames.
// - The converter-count field gives one converter for 0, two for 1, four for 3, eight for 7, and resets to 1.
// - The control-bits field in bits 7:6 gives no control bits for 0 and control bit 2 alone for 1; it resets to 0.
// - Control-bits code 2 inserts control bits 2 and 1, and code 3 inserts all three control bits.
`ifndef SLPC_CFG_SVH
`define SLPC_CFG_SVH
`define SLPC_IDX_SCR_L      12'h58B
`define SLPC_IDX_F          12'h58C
`define SLPC_IDX_K          12'h58D
`define SLPC_IDX_M          12'h58E
`define SLPC_IDX_CS_N       12'h58F
`define SLPC_SCR_BIT        7
`define SLPC_L_MSB          4
`define SLPC_K_MSB          4
`define SLPC_CS_MSB         7
`define SLPC_CS_LSB         6
`define SLPC_N_MSB          4
`define SLPC_RST_SCR        1'h1
`define SLPC_RST_L          5'h07
`define SLPC_RST_F          8'h00
`define SLPC_RST_K          5'h1F
`define SLPC_RST_M          8'h01
`define SLPC_RST_CS         2'h0
`define SLPC_RST_N          5'h0F
`define SLPC_RST_L_CNT      5'h08
`define SLPC_RST_F_OUT      9'h001
`define SLPC_RST_K_OUT      6'h20
`define SLPC_RST_M_CNT      5'h02
`define SLPC_RST_CS_MASK    3'h0
`define SLPC_RST_LEGAL      1'h1
`define SLPC_ADDR_W         14
`define SLPC_MASK_SCR_L     8'h9F
`define SLPC_MASK_K         8'h1F
`define SLPC_MASK_CS_N      8'hDF
`endif

// [design/slpc_pkg.sv]
// types shared by the serial link parameter block
package slpc_pkg;
  typedef logic [7:0] slpc_byte_t;
  typedef enum logic [2:0] {
    SLPC_IDLE   = 3'b001,
    SLPC_ACCESS = 3'b010,
    SLPC_DONE   = 3'b100
  } slpc_state_e;
endpackage : slpc_pkg

// [design/slpc_lane_decode.sv]
// decodes a power-of-two-minus-one count code into a count and a legal flag
`timescale 1ns/1ps
module slpc_lane_decode #(
  parameter int W = 5
) (
  input  wire logic [W-1:0] code,
  output logic      [4:0]   count,
  output logic              legal
);
  // codes 0, 1, 3, 7 map to 1, 2, 4, 8
  always_comb
  begin
    count = 5'h00;
    legal = 1'b1;
    unique case (code)
      W'(0): count = 5'h01;
      W'(1): count = 5'h02;
      W'(3): count = 5'h04;
      W'(7): count = 5'h08;
      default: legal = 1'b0;
    endcase
  end
endmodule : slpc_lane_decode

// [design/slpc_cs_decode.sv]
// decodes the control-bits code into a count and a mask of inserted control bits
`timescale 1ns/1ps
module slpc_cs_decode (
  input  wire logic [1:0] code,
  output logic      [1:0] count,
  output logic      [2:0] mask
);
  // code selects control bit 2, then 2 and 1, then all three
  always_comb
  begin
    count = code;
    unique case (code)
      2'h0: mask = 3'h0;
      2'h1: mask = 3'h4;
      2'h2: mask = 3'h6;
      2'h3: mask = 3'h7;
    endcase
  end
endmodule : slpc_cs_decode

// [design/slpc_top.sv]
// serial link parameter registers behind an APB slave
`timescale 1ns/1ps
`include "slpc_cfg.svh"
module slpc_top (
  input  wire logic                     clk_sys,
  input  wire logic                     rst_b,
  input  wire logic                     psel,
  input  wire logic                     penable,
  input  wire logic                     pwrite,
  input  wire logic [`SLPC_ADDR_W-1:0]  paddr,
  input  wire logic [31:0]              pwdata,
  input  wire logic [3:0]               pstrb,
  output logic      [31:0]              prdata,
  output logic                          pready,
  output logic                          pslverr,
  output logic                          scr_en,
  output logic      [4:0]               lane_code,
  output logic      [4:0]               lane_count,
  output logic      [8:0]               octets_per_frame,
  output logic      [5:0]               frames_per_mf,
  output logic      [4:0]               conv_count,
  output logic      [1:0]               ctrl_bit_count,
  output logic      [2:0]               ctrl_bit_mask,
  output logic      [4:0]               resolution_code,
  output logic                          cfg_legal
);
  import slpc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // storage
  slpc_state_e      state;
  slpc_state_e      next_state;
  logic             scr;
  logic [4:0]       lanes;
  slpc_byte_t       fcfg;
  logic [4:0]       kcfg;
  slpc_byte_t       mcfg;
  logic [1:0]       cscfg;
  logic [4:0]       ncfg;
  logic             next_scr;
  logic [4:0]       next_lanes;
  slpc_byte_t       next_fcfg;
  logic [4:0]       next_kcfg;
  slpc_byte_t       next_mcfg;
  logic [1:0]       next_cscfg;
  logic [4:0]       next_ncfg;
  logic [31:0]      next_prdata;
  logic             next_pready;
  logic             next_pslverr;
  logic [11:0]      idx;
  logic             hit;
  slpc_byte_t       wbyte;
  slpc_byte_t       rbyte;
  logic             wr_now;
  logic [4:0]       l_cnt;
  logic             l_ok;
  logic [4:0]       m_cnt;
  logic             m_ok;
  logic [1:0]       cs_cnt;
  logic [2:0]       cs_mask;
  logic [12:0]      fk_prod;
  logic             next_scr_en;
  logic [4:0]       next_lane_code;
  logic [4:0]       next_lane_count;
  logic [8:0]       next_octets;
  logic [5:0]       next_frames;
  logic [4:0]       next_conv_count;
  logic [1:0]       next_ctrl_count;
  logic [2:0]       next_ctrl_mask;
  logic [4:0]       next_resolution;
  logic             next_cfg_legal;

  ////////////////////////////////////////////////////////////////////////////
  // decoders
  slpc_lane_decode #(.W(5)) u_lane (
    .code  (lanes),
    .count (l_cnt),
    .legal (l_ok)
  );
  slpc_lane_decode #(.W(8)) u_conv (
    .code  (mcfg),
    .count (m_cnt),
    .legal (m_ok)
  );
  slpc_cs_decode u_cs (
    .code  (cscfg),
    .count (cs_cnt),
    .mask  (cs_mask)
  );

  // word-aligned index decode: byte address is four times the index
  assign idx     = paddr[`SLPC_ADDR_W-1:2];
  assign wbyte   = pwdata[7:0];
  assign fk_prod = 13'((fcfg + 9'h001) * (kcfg + 6'h01));

  // read mux, reserved bits zero
  always_comb
  begin
    hit   = 1'b1;
    rbyte = 8'h00;
    unique case (idx)
      `SLPC_IDX_SCR_L: rbyte = {scr, 2'h0, lanes};
      `SLPC_IDX_F:     rbyte = fcfg;
      `SLPC_IDX_K:     rbyte = {3'h0, kcfg};
      `SLPC_IDX_M:     rbyte = mcfg;
      `SLPC_IDX_CS_N:  rbyte = {cscfg, 1'b0, ncfg};
      default:         hit   = 1'b0;
    endcase
  end

  ////////////////////////////////////////////////////////////////////////////
  // apb handshake: one wait state, answer in the second access cycle
  assign wr_now = (state == SLPC_ACCESS) && psel && penable && pwrite && hit && pstrb[0];

  always_comb
  begin
    next_state   = state;
    next_pready  = 1'b0;
    next_pslverr = 1'b0;
    next_prdata  = prdata;
    unique case (state)
      SLPC_IDLE:
      begin
        if (psel && penable)
        begin
          next_state = SLPC_ACCESS;
          next_pready = 1'b1;
          next_pslverr = !hit;
          next_prdata = (!pwrite && hit) ? {24'h000000, rbyte} : 32'h00000000;
        end
      end
      SLPC_ACCESS:
        next_state = SLPC_IDLE;
      default:
        next_state = SLPC_IDLE;
    endcase
  end

  // register writes, reserved bits dropped
  always_comb
  begin
    next_scr   = scr;
    next_lanes = lanes;
    next_fcfg  = fcfg;
    next_kcfg  = kcfg;
    next_mcfg  = mcfg;
    next_cscfg = cscfg;
    next_ncfg  = ncfg;
    if (wr_now)
    begin
      unique case (idx)
        `SLPC_IDX_SCR_L:
        begin
          next_scr   = wbyte[`SLPC_SCR_BIT];
          next_lanes = wbyte[`SLPC_L_MSB:0];
        end
        `SLPC_IDX_F:    next_fcfg = wbyte;
        `SLPC_IDX_K:    next_kcfg = wbyte[`SLPC_K_MSB:0];
        `SLPC_IDX_M:    next_mcfg = wbyte;
        `SLPC_IDX_CS_N:
        begin
          next_cscfg = wbyte[`SLPC_CS_MSB:`SLPC_CS_LSB];
          next_ncfg  = wbyte[`SLPC_N_MSB:0];
        end
        default: ;
      endcase
    end
  end

  // bus state and stored fields, registered on every clock
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      state   <= SLPC_IDLE;
      prdata  <= 32'h00000000;
      pready  <= 1'b0;
      pslverr <= 1'b0;
      scr     <= `SLPC_RST_SCR;
      lanes   <= `SLPC_RST_L;
      fcfg    <= `SLPC_RST_F;
      kcfg    <= `SLPC_RST_K;
      mcfg    <= `SLPC_RST_M;
      cscfg   <= `SLPC_RST_CS;
      ncfg    <= `SLPC_RST_N;
    end
    else
    begin
      state   <= next_state;
      prdata  <= next_prdata;
      pready  <= next_pready;
      pslverr <= next_pslverr;
      scr     <= next_scr;
      lanes   <= next_lanes;
      fcfg    <= next_fcfg;
      kcfg    <= next_kcfg;
      mcfg    <= next_mcfg;
      cscfg   <= next_cscfg;
      ncfg    <= next_ncfg;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // next decoded link parameters from the stored fields
  always_comb
  begin
    next_scr_en     = scr;
    next_lane_code  = lanes;
    next_lane_count = l_cnt;
    next_octets     = {1'b0, fcfg} + 9'h001;
    next_frames     = {1'b0, kcfg} + 6'h01;
    next_conv_count = m_cnt;
    next_ctrl_count = cs_cnt;
    next_ctrl_mask  = cs_mask;
    next_resolution = ncfg;
    next_cfg_legal  = l_ok && m_ok && (fk_prod[1:0] == 2'h0);
  end

  // registered decoded link parameters, so every output leaves a flip-flop
  always_ff @(posedge clk_sys or negedge rst_b)
  begin
    if (!rst_b)
    begin
      scr_en           <= `SLPC_RST_SCR;
      lane_code        <= `SLPC_RST_L;
      lane_count       <= `SLPC_RST_L_CNT;
      octets_per_frame <= `SLPC_RST_F_OUT;
      frames_per_mf    <= `SLPC_RST_K_OUT;
      conv_count       <= `SLPC_RST_M_CNT;
      ctrl_bit_count   <= `SLPC_RST_CS;
      ctrl_bit_mask    <= `SLPC_RST_CS_MASK;
      resolution_code  <= `SLPC_RST_N;
      cfg_legal        <= `SLPC_RST_LEGAL;
    end
    else
    begin
      scr_en           <= next_scr_en;
      lane_code        <= next_lane_code;
      lane_count       <= next_lane_count;
      octets_per_frame <= next_octets;
      frames_per_mf    <= next_frames;
      conv_count       <= next_conv_count;
      ctrl_bit_count   <= next_ctrl_count;
      ctrl_bit_mask    <= next_ctrl_mask;
      resolution_code  <= next_resolution;
      cfg_legal        <= next_cfg_legal;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // checks: writes land in the stored fields, and decoded outputs follow the stored fields one clock later
  a_scr_follow: assert property (@(posedge clk_sys) disable iff (!rst_b)
    scr_en == $past(scr)) else $error("scrambler enable lags bit");
  a_scr_write: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (wr_now && idx == `SLPC_IDX_SCR_L) |=> (scr == $past(wbyte[`SLPC_SCR_BIT])))
    else $error("scrambler write lost");
  a_lane_one: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (lanes == 5'h00) |=> (lane_count == 5'h01)) else $error("one lane wrong");
  a_lane_map: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (lanes == 5'h03) |=> (lane_count == 5'h04)) else $error("lane map wrong");
  a_lane_eight: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (lanes == 5'h07) |=> (lane_count == 5'h08)) else $error("eight lanes wrong");
  a_f_plus_one: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ##1 octets_per_frame == {1'b0, $past(fcfg)} + 9'h001) else $error("F decode wrong");
  a_write_lands: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (wr_now && idx == `SLPC_IDX_F) |=> (fcfg == $past(wbyte))) else $error("F write lost");
  a_k_plus_one: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (kcfg == 5'h1F) |=> (frames_per_mf == 6'h20)) else $error("K decode wrong");
  a_k_follow: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ##1 frames_per_mf == {1'b0, $past(kcfg)} + 6'h01) else $error("K follow wrong");

  // legality status of the frame and multiframe product
  a_fk_legal: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ((fk_prod[1:0] != 2'h0) && l_ok && m_ok) |=> !cfg_legal) else $error("F times K check wrong");
  a_fk_ok: assert property (@(posedge clk_sys) disable iff (!rst_b)
    ((fk_prod[1:0] == 2'h0) && l_ok && m_ok) |=> cfg_legal) else $error("legal setting refused");

  // converter and control-bit decode tables
  a_conv_one: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (mcfg == 8'h00) |=> (conv_count == 5'h01)) else $error("one converter wrong");
  a_conv_two: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (mcfg == 8'h01) |=> (conv_count == 5'h02)) else $error("two converters wrong");
  a_conv_four: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (mcfg == 8'h03) |=> (conv_count == 5'h04)) else $error("four converters wrong");
  a_conv_map: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (mcfg == 8'h07) |=> (conv_count == 5'h08)) else $error("converter map wrong");
  a_cs_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (cscfg == 2'h0) |=> (ctrl_bit_mask == 3'h0 && ctrl_bit_count == 2'h0)) else $error("CS zero wrong");
  a_cs_one: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (cscfg == 2'h1) |=> (ctrl_bit_mask == 3'h4)) else $error("CS one wrong");
  a_cs_two: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (cscfg == 2'h2) |=> (ctrl_bit_mask == 3'h6 && ctrl_bit_count == 2'h2)) else $error("CS two wrong");
  a_cs_three: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (cscfg == 2'h3) |=> (ctrl_bit_mask == 3'h7 && ctrl_bit_count == 2'h3)) else $error("CS three wrong");

  // bus side: reserved bits read back as zero
  a_rsvd_zero: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (pready && !pslverr && paddr[`SLPC_ADDR_W-1:2] == `SLPC_IDX_K) |-> (prdata[31:5] == 27'h0))
    else $error("reserved bits not zero");
  a_rsvd_scr: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (pready && !pslverr && idx == `SLPC_IDX_SCR_L) |-> (prdata[31:8] == 24'h0 && prdata[6:5] == 2'h0))
    else $error("lane register reserved bits set");
  a_rsvd_cs: assert property (@(posedge clk_sys) disable iff (!rst_b)
    (pready && !pslverr && idx == `SLPC_IDX_CS_N) |-> (prdata[31:8] == 24'h0 && prdata[5] == 1'b0))
    else $error("control register reserved bit set");
endmodule : slpc_top

// [verification/slpc_top_tb.sv]
// self-checking bench for the serial link parameter registers
`timescale 1ns/1ps
`include "slpc_cfg.svh"
`define CHK(a, b, m) begin check_count++; if ((a) !== (b)) begin failures++; $display("unexpected at %0t: %s", $time, m); end end
module slpc_top_tb;
  typedef struct {logic dat; logic [7:0] d; logic err;} slpc_exp_s;
  logic        clk_sys, rst_b, psel, penable, pwrite, pready, pslverr, scr_en, cfg_legal;
  logic [13:0] paddr;
  logic [31:0] pwdata, prdata, seed, r;
  logic [3:0]  pstrb;
  logic [4:0]  lane_code, lane_count, conv_count, resolution_code;
  logic [8:0]  octets_per_frame;
  logic [5:0]  frames_per_mf;
  logic [1:0]  ctrl_bit_count;
  logic [2:0]  ctrl_bit_mask;
  logic [7:0]  v;
  logic [2:0]  msk [4] = '{3'b000, 3'b100, 3'b110, 3'b111};
  int          failures, check_count, cycles;
  slpc_exp_s   exp_q[$];
  slpc_exp_s   em;

  slpc_top dut_u (.clk_sys(clk_sys), .rst_b(rst_b), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .pstrb(pstrb), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .scr_en(scr_en), .lane_code(lane_code), .lane_count(lane_count), .octets_per_frame(octets_per_frame),
    .frames_per_mf(frames_per_mf), .conv_count(conv_count), .ctrl_bit_count(ctrl_bit_count),
    .ctrl_bit_mask(ctrl_bit_mask), .resolution_code(resolution_code), .cfg_legal(cfg_legal));

  ////////////////////////////////////////////////////////////////////////////////
  // clock and hang guard
  initial
  begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end
  always @(posedge clk_sys)
  begin
    cycles++;
    if (cycles == 4000)
    begin
      failures++;
      finish_test();
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // helpers: random source, apb master, settling
  function automatic logic [31:0] rnd();
    seed = seed ^ (seed << 13);
    seed = seed ^ (seed >> 17);
    seed = seed ^ (seed << 5);
    return seed;
  endfunction : rnd
  task automatic apb(input logic w, input logic [11:0] idx, input logic [7:0] d, input logic [3:0] st,
                     input logic [7:0] xd, input logic err);
    slpc_exp_s   e;
    logic [31:0] x;
    e.dat = !w;
    e.d = xd;
    e.err = err;
    x = rnd();
    exp_q.push_back(e);
    @(posedge clk_sys);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {idx, 2'b00};
    pwdata <= {x[23:0], d};
    pstrb <= st;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask : apb
  task automatic wr(input logic [11:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d, 4'hF, 8'h00, 1'b0);
  endtask : wr
  task automatic rd(input logic [11:0] idx, input logic [7:0] xd);
    apb(1'b0, idx, 8'h00, 4'hF, xd, 1'b0);
  endtask : rd
  task automatic settle();
    repeat (2) @(posedge clk_sys);
  endtask : settle
  task automatic finish_test();
    $display("checks %0d mismatches %0d", check_count, failures);
    if (failures == 0 && check_count > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : finish_test

  ////////////////////////////////////////////////////////////////////////////////
  // monitor: each answer is matched against the oldest note
  always @(posedge clk_sys)
  begin
    if (pready === 1'b1)
    begin
      if (exp_q.size() == 0)
        `CHK(1'b0, 1'b1, "answer with no request")
      else
      begin
        em = exp_q.pop_front();
        `CHK(pslverr, em.err, "error flag")
        if (em.dat)
          `CHK(prdata, ({24'h000000, em.d}), "read data")
      end
    end
  end

  ////////////////////////////////////////////////////////////////////////////////
  // main sequence
  initial
  begin
    seed = 32'h0000000A;
    rst_b = 1'b0;
    {psel, penable, pwrite} = 3'b000;
    paddr = 14'h0000;
    pwdata = 32'h00000000;
    pstrb = 4'hF;
    repeat (3) @(posedge clk_sys);
    rst_b <= 1'b1;
    @(posedge clk_sys);
    `CHK(scr_en, 1'b1, "scrambler reset")
    `CHK(lane_count, 5'h08, "lane reset")
    `CHK(octets_per_frame, 9'h001, "octet reset")
    `CHK(frames_per_mf, 6'h20, "frame reset")
    `CHK(conv_count, 5'h02, "converter reset")
    `CHK(ctrl_bit_count, 2'h0, "control reset")
    `CHK(ctrl_bit_mask, 3'h0, "mask reset")
    `CHK(lane_code, 5'h07, "lane code reset")
    `CHK(resolution_code, 5'h0F, "resolution reset")
    `CHK(cfg_legal, 1'b1, "legal reset")
    rd(`SLPC_IDX_SCR_L, 8'h87);
    rd(`SLPC_IDX_F, 8'h00);
    rd(`SLPC_IDX_K, 8'h1F);
    rd(`SLPC_IDX_M, 8'h01);
    rd(`SLPC_IDX_CS_N, 8'h0F);
    $display("test reset done");
    // each legal lane and converter code (0, 1, 3, 7) and every control code, reserved bits set on write
    for (int i = 0; i < 4; i++)
    begin
      v = 8'((1 << i) - 1);
      wr(`SLPC_IDX_SCR_L, {~i[0], 2'b11, v[4:0]});
      rd(`SLPC_IDX_SCR_L, {~i[0], 2'b00, v[4:0]});
      wr(`SLPC_IDX_M, v);
      rd(`SLPC_IDX_M, v);
      wr(`SLPC_IDX_CS_N, {i[1:0], 1'b1, v[4:0]});
      rd(`SLPC_IDX_CS_N, {i[1:0], 1'b0, v[4:0]});
      settle();
      `CHK(scr_en, ~i[0], "scrambler")
      `CHK(lane_count, 5'(1 << i), "lanes")
      `CHK(conv_count, 5'(1 << i), "converters")
      `CHK(ctrl_bit_count, i[1:0], "control count")
      `CHK(ctrl_bit_mask, msk[i], "control mask")
      `CHK(lane_code, v[4:0], "lane code")
      `CHK(resolution_code, v[4:0], "resolution")
    end
    $display("test codes done");
    // random and boundary frame sizes
    for (int i = 0; i < 5; i++)
    begin
      r = (i == 0) ? 32'h00E0FF00 : rnd();
      wr(`SLPC_IDX_F, r[7:0]);
      rd(`SLPC_IDX_F, r[7:0]);
      wr(`SLPC_IDX_K, r[15:8]);
      rd(`SLPC_IDX_K, {3'b000, r[12:8]});
      settle();
      `CHK(octets_per_frame, 9'(r[7:0]) + 9'h001, "octets")
      `CHK(frames_per_mf, 6'(r[12:8]) + 6'h01, "frames")
      `CHK(cfg_legal, ((r[7:0] + 1) * (r[12:8] + 1)) % 4 == 0, "legal")
    end
    $display("test frames done");
    // unmapped places and a write with its byte lane off
    apb(1'b0, 12'h58A, 8'h00, 4'hF, 8'h00, 1'b1);
    apb(1'b1, 12'h590, 8'h5A, 4'hF, 8'h00, 1'b1);
    apb(1'b1, `SLPC_IDX_F, ~r[7:0], 4'hE, 8'h00, 1'b0);
    rd(`SLPC_IDX_F, r[7:0]);
    settle();
    `CHK(exp_q.size(), 0, "answers missing")
    $display("test refusals done");
    finish_test();
  end
endmodule : slpc_top_tb
